// ===== cvbh_fifo.sv
package cvbh_pkg;

  // Bit history and reset pattern
  localparam int            HIST_LEN_DEF    = 4;
  localparam logic [3:0]    HIST_RST        = 4'h5;
  localparam logic          OUT_RST         = 1'b1;
  localparam logic          SLOPE_RST       = 1'b0;

  // System clock
  localparam int            CLK_PERIOD_NS   = 40;

  // Codec clock shape limits
  localparam int            CLK_HIGH_MIN_NS = 300;
  localparam int            CLK_LOW_MIN_NS  = 900;
  localparam int            CLK_HIGH_CYC    = (CLK_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int            CLK_LOW_CYC     = (CLK_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Level counter
  localparam int            CNT_W           = 5;
  localparam logic [4:0]    CNT_MAX         = 5'h1f;
  localparam logic [4:0]    CNT_ONE         = 5'h01;

  // Output buffer
  localparam int            FIFO_DEPTH_DEF  = 8;

  typedef enum logic [1:0] {
    ST_LOW   = 2'h0,
    ST_HIGH  = 2'h1,
    ST_ARMED = 2'h3
  } cvbh_phase_e;

endpackage : cvbh_pkg

`timescale 1ns/10ps

module cvbh_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [CW-1:0]    count_ff;
  logic             out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;
  logic             push;
  logic             pop;

  // Output stage refills from the array whenever it is empty or being taken
  assign in_ready  = (count_ff != CW'(DEPTH));
  assign push      = in_valid && in_ready;
  assign pop       = (count_ff != '0) && (!out_valid_ff || out_ready);
  assign out_valid = out_valid_ff;
  assign out_data  = out_data_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
    end else if (push) begin
      wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + AW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_ff <= '0;
    end else if (pop) begin
      rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + AW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= '0;
    end else if (push && !pop) begin
      count_ff <= count_ff + CW'(1);
    end else if (pop && !push) begin
      count_ff <= count_ff - CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_ff <= 1'b0;
      out_data_ff  <= '0;
    end else if (pop) begin
      out_valid_ff <= 1'b1;
      out_data_ff  <= mem_ff[rd_ptr_ff];
    end else if (out_ready) begin
      out_valid_ff <= 1'b0;
    end
  end

endmodule : cvbh_fifo

// ===== cvbh_top.sv
`timescale 1ns/10ps

module cvbh_top
  import cvbh_pkg::*;
#(
  parameter int HIST_LEN   = HIST_LEN_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input  wire logic                CLOCK,
  input  wire logic                RESET_N,
  input  wire logic                CODEC_CLK,
  input  wire logic                ENC_SEL,
  input  wire logic                CMP_ABOVE,
  input  wire logic                DATA_IN,
  input  wire logic                CLR_FLAGS,
  output logic                     DIGITAL_OUT,
  output logic                     SLOPE_UP,
  output logic                     COINC_N_O,
  output logic                     COINC_N_OE,
  output logic                     TIMING_ERR,
  output logic                     OVERRUN,
  output logic                     HIST_VALID,
  output logic [HIST_LEN:0]        HIST_DATA,
  input  wire logic                HIST_READY
);

  logic                codec_prev_ff;
  logic                codec_rise;
  logic                codec_fall;
  cvbh_phase_e         phase_ff;
  cvbh_phase_e         nxt_phase;
  logic [CNT_W-1:0]    level_cnt_ff;
  logic                high_ok;
  logic                low_ok;
  logic                sample;
  logic                glitch;
  logic                new_bit;
  logic [HIST_LEN-1:0] hist_ff;
  logic [HIST_LEN-1:0] nxt_hist;
  logic                nxt_coinc;
  logic                digital_out_ff;
  logic                slope_up_ff;
  logic                coinc_o_ff;
  logic                coinc_oe_ff;
  logic                timing_err_ff;
  logic                overrun_ff;
  logic                fifo_in_ready;

  // Codec clock is a sampled level, not a clock; edges found by comparison
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      codec_prev_ff <= 1'b0;
    end else begin
      codec_prev_ff <= CODEC_CLK;
    end
  end

  assign codec_rise = CODEC_CLK && !codec_prev_ff;
  assign codec_fall = !CODEC_CLK && codec_prev_ff;

  // Samples spent at the present codec clock level, saturating
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      level_cnt_ff <= CNT_MAX;
    end else if (codec_rise || codec_fall) begin
      level_cnt_ff <= CNT_ONE;
    end else if (level_cnt_ff != CNT_MAX) begin
      level_cnt_ff <= level_cnt_ff + CNT_ONE;
    end
  end

  assign high_ok = (level_cnt_ff >= CNT_W'(CLK_HIGH_CYC));
  assign low_ok  = (level_cnt_ff >= CNT_W'(CLK_LOW_CYC));

  always_comb begin
    nxt_phase = phase_ff;
    case (phase_ff)
      ST_LOW: begin
        if (codec_rise) begin
          nxt_phase = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (codec_fall) begin
          nxt_phase = ST_LOW;
        end else if (high_ok) begin
          nxt_phase = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (codec_fall) begin
          nxt_phase = ST_LOW;
        end
      end
      default: begin
        nxt_phase = ST_LOW;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_ff <= ST_LOW;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Falling-edge only update
  // A high pulse shorter than the minimum is a glitch; shifting on it
  // would corrupt the history on both ends of the link
  assign sample = codec_fall && ((phase_ff == ST_ARMED) || (phase_ff == ST_HIGH && high_ok));
  assign glitch = codec_fall && !sample;

  assign new_bit = ENC_SEL ? !CMP_ABOVE : !DATA_IN;

  assign nxt_hist  = {hist_ff[HIST_LEN-2:0], new_bit};
  assign nxt_coinc = (&nxt_hist) || !(|nxt_hist);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      hist_ff <= HIST_LEN'(HIST_RST);
    end else if (sample) begin
      hist_ff <= nxt_hist;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      digital_out_ff <= OUT_RST;
    end else if (sample) begin
      digital_out_ff <= new_bit;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      slope_up_ff <= SLOPE_RST;
    end else if (sample) begin
      slope_up_ff <= !new_bit;
    end
  end

  // Same detect in decode
  // Open-drain: enable pulls the pin low while coincidence holds
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      coinc_oe_ff <= 1'b0;
      coinc_o_ff  <= 1'b0;
    end else if (sample) begin
      coinc_oe_ff <= nxt_coinc;
      coinc_o_ff  <= 1'b0;
    end
  end

  // Clock shape error, sticky; a new error wins over a clear
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      timing_err_ff <= 1'b0;
    end else if (glitch || (codec_rise && phase_ff == ST_LOW && !low_ok)) begin
      timing_err_ff <= 1'b1;
    end else if (CLR_FLAGS) begin
      timing_err_ff <= 1'b0;
    end
  end

  // The codec clock cannot be stalled, so a full buffer drops the word
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      overrun_ff <= 1'b0;
    end else if (sample && !fifo_in_ready) begin
      overrun_ff <= 1'b1;
    end else if (CLR_FLAGS) begin
      overrun_ff <= 1'b0;
    end
  end

  cvbh_fifo #(
    .WIDTH (HIST_LEN + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .in_valid  (sample),
    .in_data   ({new_bit, nxt_hist}),
    .in_ready  (fifo_in_ready),
    .out_valid (HIST_VALID),
    .out_data  (HIST_DATA),
    .out_ready (HIST_READY)
  );

  assign DIGITAL_OUT = digital_out_ff;
  assign SLOPE_UP    = slope_up_ff;
  assign COINC_N_O   = coinc_o_ff;
  assign COINC_N_OE  = coinc_oe_ff;
  assign TIMING_ERR  = timing_err_ff;
  assign OVERRUN     = overrun_ff;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  out_stable_a: assert property (!sample |=> $stable(DIGITAL_OUT))
    else $error("digital output changed without a codec clock fall");

  glitch_reject_a: assert property (glitch |=> $stable(hist_ff) && TIMING_ERR)
    else $error("short codec clock pulse shifted the history");

  hist_shift_a: assert property (sample |=> hist_ff == {$past(hist_ff[HIST_LEN-2:0]), DIGITAL_OUT})
    else $error("history did not shift in the new bit");

  coinc_flag_a: assert property (COINC_N_OE == ((&hist_ff) || !(|hist_ff)))
    else $error("coincidence flag disagrees with history");

  coinc_pin_a: assert property (COINC_N_OE |-> !COINC_N_O)
    else $error("coincidence pin driven high");

  enc_load_a: assert property (sample && ENC_SEL |=> DIGITAL_OUT == !$past(CMP_ABOVE))
    else $error("encode bit is not the inverted comparator result");

  dec_load_a: assert property (sample && !ENC_SEL |=> DIGITAL_OUT == !$past(DATA_IN))
    else $error("decode bit is not the inverted data input");

  slope_dir_a: assert property (SLOPE_UP != DIGITAL_OUT)
    else $error("slope direction does not follow the sign bit");

  slope_enc_a: assert property (sample && ENC_SEL && CMP_ABOVE |=> SLOPE_UP)
    else $error("encode slope not into integrator");

  slope_dec_a: assert property (sample && !ENC_SEL |=> SLOPE_UP == $past(DATA_IN))
    else $error("decode slope does not follow data bit");

  idle_toggle_a: assert property (sample && !ENC_SEL && DATA_IN == DIGITAL_OUT
                                  |=> DIGITAL_OUT != $past(DIGITAL_OUT))
    else $error("looped data path did not toggle");

  one_bit_a: assert property (sample |=> !sample ##1 !sample)
    else $error("more than one bit taken per codec clock");

  overrun_set_a: assert property (sample && !fifo_in_ready |=> OVERRUN)
    else $error("dropped history word not flagged");

endmodule : cvbh_top

// ===== cvbh_codec_model.sv
`timescale 1ns/10ps

module cvbh_codec_model (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              codec_clk,
  input  wire logic              slope_up,
  input  wire logic signed [7:0] target,
  output logic                   cmp_above
);
  logic              clk_d_ff;
  logic signed [7:0] integ_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_d_ff <= 1'b0;
      integ_ff <= 8'sh00;
    end else begin
      clk_d_ff <= codec_clk;
      // one ramp step per bit
      // Stepping on the rise keeps the compare stable while low
      if (codec_clk && !clk_d_ff) begin
        integ_ff <= slope_up ? integ_ff + 8'sh01 : integ_ff - 8'sh01;
      end
    end
  end

  assign cmp_above = target > integ_ff;
endmodule : cvbh_codec_model

// ===== cvsd_bit_history_logic_tb_top.sv
`timescale 1ns/10ps

module cvsd_bit_history_logic_tb_top;
  import cvbh_pkg::*;
  logic              clock, rst_n, codec_clk, enc_sel, tb_cmp, data_in, clr_flags;
  logic              hist_ready, use_model, dig_out, slope_up, coinc_o, coinc_oe;
  logic              timing_err, overrun, hist_valid, cmp_above, model_cmp, exp_out, p;
  logic        [4:0] hist_data;
  logic signed [7:0] target;
  logic        [3:0] exp_hist;
  logic        [4:0] exp_q[$];
  int                error_cnt, n_tests, seed, k;

  always #20 clock = ~clock;
  assign cmp_above = use_model ? model_cmp : tb_cmp;

  cvbh_top u_cvbh_top (.CLOCK(clock), .RESET_N(rst_n), .CODEC_CLK(codec_clk),
    .ENC_SEL(enc_sel), .CMP_ABOVE(cmp_above), .DATA_IN(data_in), .CLR_FLAGS(clr_flags),
    .DIGITAL_OUT(dig_out), .SLOPE_UP(slope_up), .COINC_N_O(coinc_o), .COINC_N_OE(coinc_oe),
    .TIMING_ERR(timing_err), .OVERRUN(overrun), .HIST_VALID(hist_valid),
    .HIST_DATA(hist_data), .HIST_READY(hist_ready));

  cvbh_codec_model u_cvbh_codec_model (.clk(clock), .rst_n(rst_n), .codec_clk(codec_clk),
    .slope_up(slope_up), .target(target), .cmp_above(model_cmp));

  task automatic summarize;
    $display("Errors %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic chkw(input logic [4:0] got, input logic [4:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkw

  // One codec period: hi samples high, then lo samples low
  task automatic bit_cycle(input int hi, input int lo, input logic enc, input logic din,
                           input logic cmp);
    logic drop;
    drop = 1'b0;
    codec_clk <= 1'b1;
    repeat (hi) @(posedge clock);
    codec_clk <= 1'b0;
    enc_sel   <= enc;
    data_in   <= din;
    tb_cmp    <= cmp;
    // Occupancy before the taking edge; a pop on that edge does not free room
    @(negedge clock);
    drop = (hi >= 8) && (exp_q.size() > FIFO_DEPTH_DEF);
    @(posedge clock);
    #1;
    if (hi >= 8) begin
      exp_out  = enc ? !cmp_above : !din;
      exp_hist = {exp_hist[2:0], exp_out};
      if (!drop) exp_q.push_back({exp_out, exp_hist});
    end
    @(posedge clock);
    #1;
    chk1(dig_out, exp_out);
    chk1(slope_up, !exp_out);
    chk1(coinc_oe, exp_hist == 4'h0 || exp_hist == 4'hf);
    chk1(coinc_o, 1'b0);
    chk1(timing_err, hi < 8);
    if (drop) chk1(overrun, 1'b1);
    repeat (lo - 2) @(posedge clock);
    chk1(dig_out, exp_out);
  endtask : bit_cycle

  // Words leave the buffer in push order
  always @(posedge clock) begin
    if (rst_n && hist_valid === 1'b1 && hist_ready) begin
      chkw(hist_data, exp_q.size() != 0 ? exp_q.pop_front() : 5'bx);
    end
  end

  initial begin
    clock = 0; rst_n = 0; codec_clk = 1; enc_sel = 1; tb_cmp = 0; data_in = 0;
    clr_flags = 0; hist_ready = 1; use_model = 0; target = 8'sh00;
    exp_hist = 4'h5; exp_out = 1; seed = 77457; error_cnt = 0; n_tests = 0;
    repeat (20) @(posedge clock);
    chk1(dig_out, 1'b1);
    chk1(slope_up, 1'b0);
    chk1(coinc_oe, 1'b0);
    chk1(hist_valid, 1'b0);
    rst_n <= 1'b1;
    @(posedge clock);
    repeat (40) begin
      hist_ready <= ($random(seed) % 4) != 0;
      bit_cycle(8 + ($random(seed) & 3), 23 + ($random(seed) & 7), $random(seed),
                $random(seed), $random(seed));
    end
    hist_ready <= 1'b1;
    repeat (5) bit_cycle(8, 23, 1'b1, 1'b0, 1'b1);
    repeat (5) bit_cycle(8, 23, 1'b0, 1'b0, 1'b0);
    // Data output looped back into data input
    repeat (6) bit_cycle(8, 23, 1'b0, exp_out, 1'b0);
    bit_cycle(5, 23, 1'b1, 1'b0, 1'b0);
    clr_flags <= 1'b1;
    @(posedge clock);
    clr_flags <= 1'b0;
    @(posedge clock);
    #1;
    chk1(timing_err, 1'b0);
    use_model <= 1'b1;
    // Integrator may have wandered far during random bits; one step per bit
    repeat (70) bit_cycle(8, 23, 1'b1, 1'b0, 1'b0);
    repeat (4) begin
      p = exp_out;
      bit_cycle(8, 23, 1'b1, 1'b0, 1'b0);
      chk1(dig_out, !p);
    end
    // Consumer stalls until the buffer refuses
    use_model  <= 1'b0;
    hist_ready <= 1'b0;
    repeat (10) bit_cycle(8, 23, 1'b1, 1'b0, $random(seed));
    hist_ready <= 1'b1;
    for (k = 0; k < 200 && hist_valid !== 1'b0; k++) @(posedge clock);
    if (k == 200) begin
      error_cnt++;
    end else begin
      chk1(hist_valid, 1'b0);
      chkw(5'(exp_q.size()), 5'h00);
    end
    summarize();
  end
endmodule : cvsd_bit_history_logic_tb_top
